// *** logic/sec_pkg.sv ***
// sec_pkg: constants and types for the exception-control block
// assumes a 32-bit apb slave and a 200 MHz clock
package sec_pkg;
  // apb byte addresses of the registers
  localparam logic [7:0] ADDR_STATUS_ONE = 8'h00;
  localparam logic [7:0] ADDR_STATUS_TWO = 8'h04;
  localparam logic [7:0] ADDR_STATUS_THREE = 8'h08;
  localparam logic [7:0] ADDR_CONFIG = 8'h0C;
  localparam logic [7:0] ADDR_STATE = 8'h10;
  // config register field positions and reset value
  localparam int CFG_SHORT_REC_BIT = 0;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  // flag positions across the 24-bit flag vector (bit n = flag n)
  localparam int FLAG_EXT = 1;
  localparam int FLAG_CH_A = 3;
  localparam int FLAG_CH_B = 4;
  localparam int FLAG_WRAP = 5;
  localparam int FLAG_KEY = 14;
  localparam int FLAG_CONV = 15;
  // vector constants handed to the core (low byte address)
  localparam logic [15:0] VEC_RESET = 16'hFFFE;
  localparam logic [15:0] VEC_SWI = 16'hFFFC;
  localparam logic [15:0] VEC_EXT = 16'hFFFA;
  localparam logic [15:0] VEC_CH_A = 16'hFFF6;
  localparam logic [15:0] VEC_CH_B = 16'hFFF4;
  localparam logic [15:0] VEC_WRAP = 16'hFFF2;
  localparam logic [15:0] VEC_KEY = 16'hFFE0;
  localparam logic [15:0] VEC_CONV = 16'hFFDE;
  // stop recovery in fast clock cycles
  localparam int REC_LONG_CYC = 4096;
  localparam int REC_SHORT_CYC = 32;
  localparam logic [12:0] CNT_ZERO = 13'h0000;
  localparam logic [12:0] CNT_ONE = 13'h0001;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {
    SEC_RUN = 2'b00,
    SEC_STOP = 2'b01,
    SEC_RECOVER = 2'b11
  } sec_mode_e;

  // source requests, one bit per source, as seen by arbitration
  typedef struct packed {
    logic ext;
    logic ch_a;
    logic ch_b;
    logic wrap;
    logic key;
    logic conv;
  } sec_src_s;

  // stacking controls handed to the core on entry
  typedef struct packed {
    logic take;
    logic [15:0] vector;
    logic push_pc_minus_one;
    logic set_global_mask;
  } sec_entry_s;
endpackage : sec_pkg

// *** logic/sec_exception_ctrl.sv ***
// sec_exception_ctrl: latches and arbitrates requests, steers the core's
// vector fetch, times stop recovery and shows pending flags over apb.
// assumes the core pulses instr_done at each instruction boundary and
// pulses entry_done when stacking for the chosen vector is finished.
// paddr and pwdata are stable through both apb phases.
// all reset inputs are synchronous levels on clk.
//
// What this block does
// - after power-up reset, oscillator enable turns on for clock machine
// - stop instruction clears the recovery counter to zero
// - on stop exit, sample short bit: wait 32 or 4096 cycles
// - pin reset leaves counter alone; counter free-runs after resets
// - latch requests, arbitrate at processing start, give constant vector
// - latched request not displaced until serviced or a reset clears it
// - entry makes the core stack registers and set global mask
// - return from service makes the core unstack registers
// - hardware requests examined only when current instruction completes
// - take hardware request only if mask clear and source enabled
// - highest priority pending request wins
// - request pending at return is taken before next instruction
// - entry does not stack the upper index register
// - software trap ignores global mask; mask gates all others
// - software trap stacks pc; hardware stacks pc minus one
// - reset, trap, external line, channel a: fixed top priorities
// - then channel b, wrap, keypad, conversion, lowest last
// - flags show live requests; low two bits of first read zero
// - srst, pin and internal resets share highest priority without arbitration
// - break output forces the software trap vector fetch
`timescale 1ns/1ps
module sec_exception_ctrl (
  input wire logic clk,
  input wire logic srst,
  // reset sources
  input wire logic power_up_reset_signal,
  input wire logic internal_reset,
  input wire logic pin_reset,
  // core handshake
  input wire logic instr_done,
  input wire logic global_mask,
  input wire logic swi_exec,
  input wire logic stop_exec,
  input wire logic return_from_service,
  input wire logic entry_done,
  input wire logic break_req,
  // sources (flag and its own enable)
  input wire sec_pkg::sec_src_s src_flag,
  input wire sec_pkg::sec_src_s src_enable,
  // outputs to core
  output sec_pkg::sec_entry_s entry,
  output logic unstack,
  output logic stack_upper_index,
  output logic osc_enable,
  output logic core_clk_enable,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  sec_pkg::sec_mode_e mode_q;
  logic [12:0] cnt_q;
  logic [12:0] rec_target_q;
  logic [7:0] config_q;
  logic latched_q;
  logic [15:0] latched_vec_q;
  logic latched_hw_q;
  logic osc_q;
  logic [23:0] flags;
  sec_pkg::sec_src_s live;
  logic [15:0] pick_vec;
  logic pick_any;
  logic apb_acc;
  logic wake;

  // decode and request terms
  logic wake_src;
  logic wake_rst;
  logic any_reset;
  logic running;
  logic at_boundary;
  logic trap_req;
  logic hw_req;
  logic short_sel;
  logic rec_done;

  // apb side
  logic apb_setup;
  logic hit_one;
  logic hit_two;
  logic hit_three;
  logic hit_cfg;
  logic hit_state;
  logic hit_any;
  logic cfg_write;
  logic [7:0] status_one;
  logic [7:0] status_two;
  logic [7:0] status_three;
  logic [31:0] state_word;
  logic [31:0] rd_d;

  // requests below come from live source flags
  // gate by source enable
  assign live = src_flag & src_enable;
  // any enabled request, break, pin reset or internal reset ends stop
  assign wake_src = (live != '0) | break_req;
  assign wake_rst = pin_reset | internal_reset;
  assign wake = wake_src | wake_rst;

  // srst, internal and pin resets act alike on the latch; power-up reset does not
  assign any_reset = srst | internal_reset | pin_reset;
  assign running = (mode_q == sec_pkg::SEC_RUN);
  // the core never reports boundaries while halted; gate anyway
  assign at_boundary = instr_done & running;
  assign trap_req = break_req | swi_exec;
  assign hw_req = at_boundary & ~global_mask & pick_any;

  // apb phase and address decode
  // only the setup cycle selects read data
  assign apb_setup = psel & ~penable;
  assign apb_acc = psel & penable;
  assign hit_one = (paddr == sec_pkg::ADDR_STATUS_ONE);
  assign hit_two = (paddr == sec_pkg::ADDR_STATUS_TWO);
  assign hit_three = (paddr == sec_pkg::ADDR_STATUS_THREE);
  assign hit_cfg = (paddr == sec_pkg::ADDR_CONFIG);
  assign hit_state = (paddr == sec_pkg::ADDR_STATE);
  assign hit_any = hit_one | hit_two | hit_three | hit_cfg | hit_state;
  assign cfg_write = apb_acc & pwrite & hit_cfg;

  // default vector keeps pick_vec defined when nothing pends
  // fixed descending priority
  always_comb begin
    pick_any = 1'b1;
    pick_vec = sec_pkg::VEC_CONV;
    if (live.ext) begin
      pick_vec = sec_pkg::VEC_EXT;
    end else if (live.ch_a) begin
      pick_vec = sec_pkg::VEC_CH_A;
    end else if (live.ch_b) begin
      pick_vec = sec_pkg::VEC_CH_B;
    end else if (live.wrap) begin
      pick_vec = sec_pkg::VEC_WRAP;
    end else if (live.key) begin
      pick_vec = sec_pkg::VEC_KEY;
    end else if (live.conv) begin
      pick_vec = sec_pkg::VEC_CONV;
    end else begin
      pick_any = 1'b0;
    end
  end

  // one register per field of the latched request
  // latch flag: set by a taken request, freed when stacking ends
  always_ff @(posedge clk) begin
    if (any_reset) begin
      latched_q <= 1'b0;
    end else if (latched_q) begin
      // hold until serviced; later requests wait their turn
      if (entry_done) begin
        latched_q <= 1'b0;
      end
    end else if (trap_req) begin
      // trap ignores global mask
      // a trap seen outside run cannot stack, so it is dropped
      latched_q <= running;
    end else if (hw_req) begin
      latched_q <= 1'b1;
    end
  end

  // vector of the latched request, constant while latched
  always_ff @(posedge clk) begin
    if (any_reset) begin
      latched_vec_q <= sec_pkg::VEC_RESET;
    end else if (!latched_q) begin
      if (trap_req) begin
        latched_vec_q <= sec_pkg::VEC_SWI;
      end else if (hw_req) begin
        latched_vec_q <= pick_vec;
      end
    end
  end

  // stacking flavour of the latched request
  always_ff @(posedge clk) begin
    if (any_reset) begin
      latched_hw_q <= 1'b0;
    end else if (!latched_q) begin
      if (trap_req) begin
        latched_hw_q <= 1'b0;
      end else if (hw_req) begin
        latched_hw_q <= 1'b1;
      end
    end
  end

  // take also asks the core to set its global mask
  // entry stacks and sets mask
  // pc minus one for hardware only
  always_comb begin
    entry.take = latched_q;
    entry.vector = latched_vec_q;
    entry.push_pc_minus_one = latched_hw_q;
    entry.set_global_mask = latched_q;
  end
  // combinational echo, the core owns the stack pointer
  // return unstacks registers
  assign unstack = return_from_service;
  // service routines must save that register themselves
  // upper index never stacked
  assign stack_upper_index = 1'b0;

  // sticky: only srst stops it; stop mode gates the core
  // clock instead of the oscillator
  // oscillator on after power-up reset
  always_ff @(posedge clk) begin
    if (srst) begin
      osc_q <= 1'b0;
    end else if (power_up_reset_signal) begin
      osc_q <= 1'b1;
    end
  end
  assign osc_enable = osc_q;

  // stop mode sequencing
  always_ff @(posedge clk) begin
    if (srst) begin
      mode_q <= sec_pkg::SEC_RUN;
    end else begin
      unique case (mode_q)
        // stop instruction halts the core clock
        sec_pkg::SEC_RUN: begin
          if (stop_exec) begin
            mode_q <= sec_pkg::SEC_STOP;
          end
        end
        // counter is held at zero meanwhile
        sec_pkg::SEC_STOP: begin
          if (wake) begin
            mode_q <= sec_pkg::SEC_RECOVER;
          end
        end
        // counter times the recovery
        sec_pkg::SEC_RECOVER: begin
          if (rec_done) begin
            mode_q <= sec_pkg::SEC_RUN;
          end
        end
        // the unused code falls back to run
        default: begin
          mode_q <= sec_pkg::SEC_RUN;
        end
      endcase
    end
  end

  // sample short recovery bit when stop ends
  assign short_sel = config_q[sec_pkg::CFG_SHORT_REC_BIT];
  // ends one count early: the mode flop adds the last cycle
  assign rec_done = (cnt_q >= rec_target_q - sec_pkg::CNT_ONE);

  // recovery length, fixed for each stop exit
  always_ff @(posedge clk) begin
    if (srst) begin
      rec_target_q <= 13'(sec_pkg::REC_LONG_CYC);
    end else if (mode_q == sec_pkg::SEC_STOP && wake) begin
      if (short_sel) begin
        rec_target_q <= 13'(sec_pkg::REC_SHORT_CYC);
      end else begin
        rec_target_q <= 13'(sec_pkg::REC_LONG_CYC);
      end
    end
  end

  // recovery counter
  always_ff @(posedge clk) begin
    if (srst || internal_reset) begin
      cnt_q <= sec_pkg::CNT_ZERO;
    end else if (stop_exec || mode_q == sec_pkg::SEC_STOP) begin
      // stop clears counter
      // held at zero until recovery starts timing
      cnt_q <= sec_pkg::CNT_ZERO;
    end else begin
      // pin reset ignored; free running
      // thirteen bits, so it simply wraps in run
      cnt_q <= cnt_q + sec_pkg::CNT_ONE;
    end
  end
  // core runs only in run mode with the oscillator up
  assign core_clk_enable = osc_q && running;

  // raw flags, so software also sees disabled sources
  // live pending flags
  always_comb begin
    flags = '0;
    flags[sec_pkg::FLAG_EXT] = src_flag.ext;
    flags[sec_pkg::FLAG_CH_A] = src_flag.ch_a;
    flags[sec_pkg::FLAG_CH_B] = src_flag.ch_b;
    flags[sec_pkg::FLAG_WRAP] = src_flag.wrap;
    flags[sec_pkg::FLAG_KEY] = src_flag.key;
    flags[sec_pkg::FLAG_CONV] = src_flag.conv;
  end

  // configuration register, the only writable one
  // only the short recovery bit is used; the rest reads back
  always_ff @(posedge clk) begin
    if (srst) begin
      config_q <= sec_pkg::CONFIG_RESET;
    end else if (cfg_write) begin
      config_q <= pwdata[7:0];
    end
  end

  // in the first read flag n shows at bit n+1 and bits 1:0 read zero; later reads start at flags 7 and 15
  // byte lanes above bit 7 read zero except for the state read
  assign status_one = {flags[6:1], 2'b00};
  assign status_two = flags[14:7];
  assign status_three = flags[22:15];
  // debug view of latch, mode and low counter bits
  assign state_word = {16'h0000, latched_q, 1'b0, mode_q, cnt_q[11:0]};

  // read data mux
  always_comb begin
    rd_d = sec_pkg::RD_ZERO;
    unique case (paddr)
      sec_pkg::ADDR_STATUS_ONE: begin
        rd_d = {24'h000000, status_one};
      end
      sec_pkg::ADDR_STATUS_TWO: begin
        rd_d = {24'h000000, status_two};
      end
      sec_pkg::ADDR_STATUS_THREE: begin
        rd_d = {24'h000000, status_three};
      end
      sec_pkg::ADDR_CONFIG: begin
        rd_d = {24'h000000, config_q};
      end
      sec_pkg::ADDR_STATE: begin
        rd_d = state_word;
      end
      default: begin
        rd_d = sec_pkg::RD_ZERO;
      end
    endcase
  end

  // read data is taken in the setup cycle, so the access phase
  // never needs a wait state and pready can stay high
  always_ff @(posedge clk) begin
    if (srst) begin
      prdata <= sec_pkg::RD_ZERO;
    end else if (apb_setup && !pwrite) begin
      prdata <= rd_d;
    end
  end

  // status writes ignored; unmapped errors
  // one-cycle access phase for every address
  assign pready = 1'b1;
  // unmapped addresses answer with an error and zero data
  assign pslverr = apb_acc & ~hit_any;
endmodule : sec_exception_ctrl

// *** dv/sec_core_model.sv ***
// sec_core_model: core side, ends stacking after a chosen lag
// assumes take stays high until entry_done has been seen
`timescale 1ns/1ps
module sec_core_model (
  input wire logic clk,
  input wire logic take,
  input wire logic [3:0] lag,
  output logic entry_done
);
  logic [3:0] cnt_q = 4'h0;
  initial entry_done = 1'h0;
  always @(posedge clk) begin
    entry_done <= 1'h0;
    if (!take || entry_done) begin
      cnt_q <= 4'h0;
    end else if (cnt_q == lag) begin
      entry_done <= 1'h1;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule : sec_core_model

// *** dv/sec_exception_ctrl_assertions.sv ***
// sec_exception_ctrl_assertions: port checks of the exception block
// assumes it is bound into every sec_exception_ctrl
`timescale 1ns/1ps
module sec_exception_ctrl_assertions (
  input wire logic clk,
  input wire logic srst,
  input wire logic power_up_reset_signal,
  input wire logic internal_reset,
  input wire logic pin_reset,
  input wire logic instr_done,
  input wire logic global_mask,
  input wire logic swi_exec,
  input wire logic return_from_service,
  input wire logic entry_done,
  input wire logic break_req,
  input wire sec_pkg::sec_src_s src_flag,
  input wire sec_pkg::sec_src_s src_enable,
  input wire sec_pkg::sec_entry_s entry,
  input wire logic unstack,
  input wire logic stack_upper_index,
  input wire logic osc_enable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  a_osc_on:
    assert property (power_up_reset_signal |=> osc_enable)
    else $error("oscillator not enabled");
  a_unstack_echo:
    assert property (unstack == return_from_service)
    else $error("unstack does not follow return");
  a_upper_kept:
    assert property (!stack_upper_index)
    else $error("upper index stacked");
  a_mask_blocks:
    assert property (!entry.take && instr_done && global_mask && !swi_exec
      && !break_req |=> !entry.take)
    else $error("masked request taken");
  a_latch_hold:
    assert property (entry.take && !entry_done && !pin_reset
      && !internal_reset |=> entry.take && $stable(entry.vector))
    else $error("latched request displaced");
  a_reset_clears:
    assert property (pin_reset || internal_reset
      |=> !entry.take && entry.vector == sec_pkg::VEC_RESET)
    else $error("reset did not clear the latch");
  a_trap_entry:
    assert property (!entry.take && swi_exec |=> entry.take
      && entry.vector == sec_pkg::VEC_SWI && !entry.push_pc_minus_one)
    else $error("trap entry wrong");
  a_break_trap:
    assert property (!entry.take && break_req
      |=> entry.take && entry.vector == sec_pkg::VEC_SWI)
    else $error("break did not force trap vector");
  a_ext_first:
    assert property (!entry.take && instr_done && !global_mask && !swi_exec
      && !break_req && src_flag.ext && src_enable.ext |=> entry.take
      && entry.vector == sec_pkg::VEC_EXT && entry.push_pc_minus_one
      && entry.set_global_mask)
    else $error("external line not taken first");
endmodule : sec_exception_ctrl_assertions

bind sec_exception_ctrl sec_exception_ctrl_assertions i_sva (
  .clk, .srst, .power_up_reset_signal, .internal_reset, .pin_reset,
  .instr_done, .global_mask,
  .swi_exec, .return_from_service, .entry_done, .break_req, .src_flag,
  .src_enable, .entry, .unstack, .stack_upper_index, .osc_enable
);

// *** dv/sec_exception_ctrl_test.sv ***
// sec_exception_ctrl_test: apb, entry and stop recovery tests
// assumes sec_core_model answers each entry
`timescale 1ns/1ps
module sec_exception_ctrl_test;
  logic clk = 1'h0, srst = 1'h1, power_up_reset_signal = 1'h0;
  logic internal_reset = 1'h0, pin_reset = 1'h0, instr_done = 1'h0;
  logic global_mask = 1'h0, swi_exec = 1'h0, stop_exec = 1'h0;
  logic return_from_service = 1'h0, break_req = 1'h0, entry_done;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, serr;
  logic unstack, stack_upper_index, osc_enable, core_clk_enable;
  logic pready, pslverr;
  logic [3:0] lag = 4'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  sec_pkg::sec_src_s src_flag = '0, src_enable = '0;
  sec_pkg::sec_entry_s entry;
  logic [15:0] vt [6] = '{sec_pkg::VEC_EXT, sec_pkg::VEC_CH_A,
    sec_pkg::VEC_CH_B, sec_pkg::VEC_WRAP, sec_pkg::VEC_KEY, sec_pkg::VEC_CONV};
  int ri [6] = '{0, 0, 0, 0, 1, 2};
  int bp [6] = '{2, 4, 5, 6, 7, 0};
  int rc [2] = '{sec_pkg::REC_LONG_CYC, sec_pkg::REC_SHORT_CYC};
  int err_total = 0, check_count = 0, cyc = 0, n;
  always #2.5 clk = ~clk;
  sec_exception_ctrl i_dut (.clk, .srst, .power_up_reset_signal,
    .internal_reset, .pin_reset, .instr_done, .global_mask, .swi_exec,
    .stop_exec, .return_from_service, .entry_done, .break_req, .src_flag,
    .src_enable, .entry, .unstack, .stack_upper_index, .osc_enable,
    .core_clk_enable, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr);
  sec_core_model i_core (.clk, .take(entry.take), .lag, .entry_done);
  task automatic chk(input string s, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s exp %h got %h", s, e, g);
    end
  endtask : chk
  task automatic test_done;
    if (err_total == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : test_done
  task automatic apb(input logic w, input logic [7:0] a, input int d);
    int k;
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= 32'(d);
    @(posedge clk);
    penable <= 1'h1;
    k = 0;
    do @(posedge clk); while (pready !== 1'h1 && ++k < 20);
    rd = prdata;
    serr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task automatic wait_take(input logic v);
    int k;
    k = 0;
    do @(posedge clk); while (entry.take !== v && ++k < 40);
    chk("take", v, entry.take);
  endtask : wait_take
  task automatic pulse_done;
    instr_done <= 1'h1;
    @(posedge clk);
    instr_done <= 1'h0;
  endtask : pulse_done
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      test_done;
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    srst <= 1'h0;
    power_up_reset_signal <= 1'h1;
    @(posedge clk);
    power_up_reset_signal <= 1'h0;
    @(posedge clk);
    chk("osc", 1, osc_enable);
    global_mask <= 1'h1;
    src_enable <= '1;
    for (int i = 0; i < 6; i++) begin
      src_flag <= 6'h20 >> i;
      apb(1'h1, sec_pkg::ADDR_STATUS_ONE, 'hFF);
      for (int j = 0; j < 3; j++) begin
        apb(1'h0, 8'(4 * j), 0);
        chk("status", ri[i] == j ? 32'h1 << bp[i] : 32'h0, rd);
      end
    end
    apb(1'h0, 8'h20, 0);
    chk("unmapped", 0, rd);
    chk("slverr", 1, serr);
    global_mask <= 1'h0;
    src_flag <= '1;
    for (int i = 0; i < 6; i++) begin
      lag <= 4'(i);
      return_from_service <= 1'h1;
      pulse_done();
      return_from_service <= 1'h0;
      wait_take(1'h1);
      chk("vector", vt[i], entry.vector);
      chk("pc_minus", 1, entry.push_pc_minus_one);
      wait_take(1'h0);
      src_flag <= src_flag & ~(6'h20 >> i);
    end
    src_flag <= '1;
    for (int i = 0; i < 2; i++) begin
      global_mask <= (i == 0);
      src_enable <= i ? '0 : '1;
      pulse_done();
      repeat (3) @(posedge clk);
      chk("refused", 0, entry.take);
    end
    global_mask <= 1'h1;
    for (int i = 0; i < 2; i++) begin
      swi_exec <= (i == 0);
      break_req <= (i == 1);
      @(posedge clk);
      swi_exec <= 1'h0;
      wait_take(1'h1);
      break_req <= 1'h0;
      chk("trap", sec_pkg::VEC_SWI, entry.vector);
      if (i == 0) chk("pc", 0, entry.push_pc_minus_one);
      wait_take(1'h0);
    end
    swi_exec <= 1'h1;
    @(posedge clk);
    swi_exec <= 1'h0;
    wait_take(1'h1);
    pin_reset <= 1'h1;
    @(posedge clk);
    pin_reset <= 1'h0;
    @(posedge clk);
    chk("pin_take", 0, entry.take);
    chk("pin_vec", sec_pkg::VEC_RESET, entry.vector);
    apb(1'h0, sec_pkg::ADDR_STATE, 0);
    chk("cnt_kept", 1, rd[11:0] != 12'h000);
    internal_reset <= 1'h1;
    @(posedge clk);
    internal_reset <= 1'h0;
    apb(1'h0, sec_pkg::ADDR_STATE, 0);
    chk("cnt_clear", 32'h1, rd);
    src_flag <= '0;
    src_enable <= '1;
    for (int i = 0; i < 2; i++) begin
      apb(1'h1, sec_pkg::ADDR_CONFIG, i);
      stop_exec <= 1'h1;
      @(posedge clk);
      stop_exec <= 1'h0;
      repeat (4) @(posedge clk);
      chk("halted", 0, core_clk_enable);
      src_flag <= 6'h20;
      n = 0;
      do @(posedge clk); while (core_clk_enable !== 1'h1 && ++n < 5000);
      chk("recovery", 1, n >= rc[i] && n <= rc[i] + 3);
      src_flag <= '0;
    end
    test_done;
  end
endmodule : sec_exception_ctrl_test
